// file: rtl/clk_gate_pkg.sv
package clk_gate_pkg;

    localparam int unsigned NUM_OUTPUTS = 10;

    // Most input clock cycles from enable rise to restarted toggling
    localparam int unsigned RESUME_MAX_REF_CYCLES = 2;

    localparam logic RESET_REF_LEVEL = 1'b0;
    localparam logic RESET_OUT_LEVEL = 1'b0;

    typedef enum logic [1:0] {
        ST_HIZ   = 2'b00,
        ST_LOW   = 2'b01,
        ST_DRIVE = 2'b10
    } gate_state_type;

    typedef struct packed {
        logic [NUM_OUTPUTS-1:0] level;
        logic [NUM_OUTPUTS-1:0] oe_n;
    } clk_pins_type;

    function automatic logic [NUM_OUTPUTS-1:0] fan(input logic bit_value);
        fan = {NUM_OUTPUTS{bit_value}};
    endfunction

endpackage

// file: rtl/ref_fall_detect.sv
`timescale 1ns/1ns
module ref_fall_detect
    import clk_gate_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    input  wire logic i_ref_clk,
    output logic      o_fall
);

    logic ref_prev_r;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            ref_prev_r <= RESET_REF_LEVEL;
        end else begin
            ref_prev_r <= i_ref_clk;
        end
    end

    // Combinational so the gate acts in the same cycle the edge is seen
    assign o_fall = ref_prev_r & ~i_ref_clk;

endmodule

// file: rtl/clock_fanout_output_gate.sv
`timescale 1ns/1ns
// Contract
// - Disable waits for next input falling edge
// - Outputs stay high impedance while request low
// - Request rise drives outputs low at once
// - Toggling resumes after falling edge, two cycles
// - Static input clock: enable acts without edges
// - Request fall alone never returns high impedance
// - Entering high impedance needs a falling edge
module clock_fanout_output_gate
    import clk_gate_pkg::*;
(
    input  wire logic    i_mclk,
    input  wire logic    i_resetn,
    input  wire logic    i_ref_clk,
    input  wire logic    i_outputs_on_request,
    output clk_pins_type o_clk_pins
);

    gate_state_type state_r;
    gate_state_type state_nxt;
    logic           out_level_r;
    logic           out_level_nxt;
    logic           ref_fall;
    logic           in_hiz;
    logic           in_low;
    logic           in_drive;
    logic           drive_now;
    logic           go_low;
    logic           go_drive;
    logic           go_hiz;

    ref_fall_detect u_fall (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_ref_clk (i_ref_clk),
        .o_fall    (ref_fall)
    );

    assign in_hiz   = (state_r == ST_HIZ);
    assign in_low   = (state_r == ST_LOW);
    assign in_drive = (state_r == ST_DRIVE);

    // Enable path bypasses the state register, so a rise drives low with no edge
    assign drive_now = ~in_hiz | i_outputs_on_request;

    // A request drop alone never releases the pins; the input edge decides
    assign go_low   = in_hiz & i_outputs_on_request;
    assign go_drive = in_low & ref_fall & i_outputs_on_request;
    assign go_hiz   = ~in_hiz & ref_fall & ~i_outputs_on_request;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HIZ: begin
                if (go_low) begin
                    state_nxt = ST_LOW;
                end else begin
                    state_nxt = ST_HIZ;
                end
            end
            ST_LOW: begin
                // Only a falling edge may move on from here
                if (go_drive) begin
                    state_nxt = ST_DRIVE;
                end else if (go_hiz) begin
                    state_nxt = ST_HIZ;
                end
            end
            ST_DRIVE: begin
                if (go_hiz) begin
                    state_nxt = ST_HIZ;
                end
            end
            default: begin
                state_nxt = ST_HIZ;
            end
        endcase
    end

    // Following the input only in drive keeps every pulse whole at both ends
    assign out_level_nxt = (state_nxt == ST_DRIVE) ? i_ref_clk : 1'b0;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_r <= ST_HIZ;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            out_level_r <= RESET_OUT_LEVEL;
        end else begin
            out_level_r <= out_level_nxt;
        end
    end

    // One level and one enable fanned to every output
    assign o_clk_pins.level = fan(out_level_r);
    assign o_clk_pins.oe_n  = fan(~drive_now);

    // Helper: input falling edges since the request rose, cleared once toggling
    logic [1:0] resume_cnt_r;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn || !i_outputs_on_request || in_drive) begin
            resume_cnt_r <= 2'h0;
        end else if (ref_fall && resume_cnt_r != 2'h3) begin
            resume_cnt_r <= resume_cnt_r + 2'h1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // Request may rise again right after a disable, so the enable follows it
    disable_on_fall_a: assert property (
        in_drive && ref_fall && !i_outputs_on_request
        |=> in_hiz && o_clk_pins.oe_n == fan(!i_outputs_on_request))
        else $error("Disable not taken on falling edge");

    drive_holds_a: assert property (
        in_drive && !ref_fall |=> !in_hiz && !o_clk_pins.oe_n[0])
        else $error("Outputs released without falling edge");

    hiz_stays_a: assert property (
        in_hiz && !i_outputs_on_request |-> o_clk_pins.oe_n == fan(1'b1))
        else $error("Outputs driven while request low");

    instant_low_a: assert property (
        in_hiz && i_outputs_on_request |-> o_clk_pins.oe_n == fan(1'b0)
            && o_clk_pins.level == fan(1'b0))
        else $error("Request rise did not drive low at once");

    resume_bound_a: assert property (
        resume_cnt_r <= 2'(RESUME_MAX_REF_CYCLES))
        else $error("Resume slower than allowed");

    static_enable_a: assert property (
        in_hiz && i_outputs_on_request && !ref_fall |=> in_low)
        else $error("Static enable not latched");

    low_kept_a: assert property (
        in_low && !ref_fall |=> !in_hiz)
        else $error("Request fall returned to high impedance");

    hiz_needs_edge_a: assert property (
        $rose(in_hiz) |-> $past(ref_fall))
        else $error("High impedance entered without falling edge");

    whole_pulse_a: assert property (
        $fell(o_clk_pins.level[0]) |-> $past(ref_fall) && !$past(i_ref_clk))
        else $error("Shortened high pulse on output");

    toggle_start_a: assert property (
        $rose(in_drive) |-> $past(ref_fall) && o_clk_pins.level == fan(1'b0))
        else $error("Toggling restarted off a falling edge");

    resume_on_fall_a: assert property (
        in_low && i_outputs_on_request && ref_fall
        |=> in_drive && o_clk_pins.level == fan(1'b0))
        else $error("Toggling not resumed on falling edge");

    drive_kept_a: assert property (
        in_drive && i_outputs_on_request |=> in_drive)
        else $error("Toggling stopped with request high");

    drive_enabled_a: assert property (
        in_drive |-> o_clk_pins.oe_n == fan(1'b0))
        else $error("Outputs released while toggling");

    drive_exit_a: assert property (
        $fell(in_drive)
        |-> in_hiz && o_clk_pins.level == fan(1'b0))
        else $error("Toggling left other than to high impedance");

    drive_wait_a: assert property (
        in_drive && !i_outputs_on_request && !ref_fall
        |=> in_drive && o_clk_pins.level[0] == $past(i_ref_clk))
        else $error("Disable taken before falling edge");

    hiz_kept_a: assert property (
        in_hiz && !i_outputs_on_request |=> in_hiz)
        else $error("High impedance left with request low");

    hiz_parked_a: assert property (
        in_hiz |-> o_clk_pins.level == fan(1'b0))
        else $error("Level not parked low under high impedance");

    enable_any_clock_a: assert property (
        in_hiz && i_outputs_on_request && ref_fall
        |=> in_low && o_clk_pins.oe_n == fan(1'b0))
        else $error("Enable lost when it met a falling edge");

    low_driven_a: assert property (
        in_low
        |-> o_clk_pins.oe_n == fan(1'b0) && o_clk_pins.level == fan(1'b0))
        else $error("Held state not driving low");

    request_drop_a: assert property (
        in_low && !i_outputs_on_request && !ref_fall |=> in_low)
        else $error("Request fall alone left the held state");

    low_exit_edge_a: assert property (
        $fell(in_low) |-> $past(ref_fall))
        else $error("Held state left without falling edge");

    level_follow_a: assert property (
        in_drive && (i_outputs_on_request || !ref_fall)
        |=> o_clk_pins.level[0] == $past(i_ref_clk))
        else $error("Output level not following input clock");

    whole_low_a: assert property (
        $rose(o_clk_pins.level[0])
        |-> in_drive && $past(in_drive) && $past(i_ref_clk))
        else $error("Shortened low pulse on output");

    disable_seen_c: cover property (in_drive ##1 in_hiz);
    enable_seen_c: cover property (in_hiz ##1 in_low ##[1:20] in_drive);
    static_low_c: cover property (in_low && !i_outputs_on_request && !ref_fall [*3]);
    low_to_hiz_c: cover property (in_low ##1 in_hiz);
    slow_resume_c: cover property (resume_cnt_r == 2'h2);

endmodule

// file: tb/oe_board_model.sv
`timescale 1ns/1ns
module oe_board_model (
    input  wire logic       i_mclk,
    input  wire logic       i_run,
    input  wire logic       i_want_on,
    input  wire logic [2:0] i_half,
    output logic            o_ref_clk,
    output logic            o_req
);
    logic [2:0] cnt_r = 3'h0;
    initial begin
        o_ref_clk = 1'b0;
        o_req = 1'b0;
    end
    // Stopped clock holds its level, a legal static input
    always @(posedge i_mclk) begin
        o_req <= i_want_on;
        cnt_r <= (cnt_r >= i_half) ? 3'h0 : cnt_r + 3'h1;
        if (i_run && cnt_r >= i_half) o_ref_clk <= ~o_ref_clk;
    end
endmodule

// file: tb/clock_fanout_output_gate_tb.sv
`timescale 1ns/1ns
module clock_fanout_output_gate_tb;
    import clk_gate_pkg::*;
    logic         i_mclk = 1'b0;
    logic         i_resetn = 1'b0;
    logic         run = 1'b1;
    logic         want = 1'b0;
    logic [2:0]   half = 3'h2;
    logic         ref_clk;
    logic         req;
    clk_pins_type pins;
    int           error_cnt = 0;
    int           cmp_count = 0;
    int           st = 0;
    int           nxt;
    logic         lvl = 1'b0;
    logic         pref = 1'b0;
    always #5 i_mclk = ~i_mclk;
    oe_board_model PM (.i_mclk(i_mclk), .i_run(run), .i_want_on(want), .i_half(half),
        .o_ref_clk(ref_clk), .o_req(req));
    clock_fanout_output_gate DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ref_clk(ref_clk),
        .i_outputs_on_request(req), .o_clk_pins(pins));
    task automatic check_vec(input string what, input logic [NUM_OUTPUTS-1:0] exp,
        input logic [NUM_OUTPUTS-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic drive(input logic r, input logic w, input int n);
        run <= r;
        want <= w;
        half <= 3'(1 + $urandom % 4);
        repeat (n) @(posedge i_mclk);
    endtask
    // Model: 0 high impedance, 1 held low, 2 toggling
    always @(posedge i_mclk) begin
        nxt = st;
        if (!i_resetn) nxt = 0;
        else if (st == 0 && req) nxt = 1;
        else if (st != 0 && pref && !ref_clk) nxt = req ? 2 : 0;
        lvl <= (nxt == 2) ? ref_clk : 1'b0;
        st <= nxt;
        pref <= i_resetn ? ref_clk : RESET_REF_LEVEL;
    end
    always @(negedge i_mclk) if (i_resetn) begin
        check_vec("oe_n", {NUM_OUTPUTS{!(st != 0 || req)}}, pins.oe_n);
        if (st != 0 || req) check_vec("level", {NUM_OUTPUTS{lvl}}, pins.level);
    end
    initial begin
        void'($urandom(32'h3d39));
        repeat (4) @(posedge i_mclk);
        i_resetn <= 1'b1;
        // Static input clock first, then a live clock must release the pins
        drive(1'b0, 1'b1, 6);
        drive(1'b0, 1'b0, 12);
        drive(1'b1, 1'b0, 20);
        repeat (300) drive($urandom % 4 != 0, $urandom % 2 != 0, 2 + $urandom % 20);
        report_and_stop();
    end
    // Worst case about 6350 cycles
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule
